// *** hdl/dpat_age_counter.v ***
// Purpose: Counts memory transfers and pulses a priority boost
// Assumes: xfer_done is a one-cycle pulse on aclk
// Notes: Boost is a single-cycle pulse for the oldest FIFO entry
`include "dpat_map.vh"

module dpat_age_counter (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire [7:0] oldest_cmd_boost_threshold,
  input wire xfer_done,
  // Results
  output wire [7:0] xfer_count,
  output wire boost
);

  reg [7:0] cnt_ff;
  reg [7:0] nxt_cnt;
  reg boost_ff;
  reg nxt_boost;

  // A setting of N boosts after N+1 transfers; >= copes with a lowered
  // threshold while the count is already past it
  always @*
  begin
    nxt_cnt = cnt_ff;
    nxt_boost = 1'b0;
    if (oldest_cmd_boost_threshold == `DPAT_THR_DISABLE)
    begin
      nxt_cnt = 8'h00;
    end
    else if (xfer_done)
    begin
      if (cnt_ff >= oldest_cmd_boost_threshold)
      begin
        nxt_cnt = 8'h00;
        nxt_boost = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  // Count state
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= 8'h00;
      boost_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      boost_ff <= nxt_boost;
    end
  end

  assign xfer_count = cnt_ff;
  assign boost = boost_ff;

endmodule // dpat_age_counter

// *** hdl/dpat_map.vh ***
// Purpose: Offsets, fields, reset values and codes of the aging/trap bank
// Assumes: Included by every design file of the block by its bare name
// Notes: Definitions only, no logic
`ifndef DPAT_MAP_VH
`define DPAT_MAP_VH

// Bus widths
`define DPAT_AW 8
`define DPAT_DW 32

// Register byte offsets
`define DPAT_OFF_THRESH 8'h00
`define DPAT_OFF_RAW 8'h04
`define DPAT_OFF_MASKED 8'h08
`define DPAT_OFF_EN_SET 8'h0C
`define DPAT_OFF_EN_CLR 8'h10
`define DPAT_OFF_AGE_STAT 8'h14

// Field positions
`define DPAT_THR_MSB 7
`define DPAT_TRAP_BIT 2
`define DPAT_CNT_LSB 0
`define DPAT_BOOSTS_LSB 8

// Reset values and special codes
`define DPAT_THR_RESET 8'hFF
`define DPAT_THR_DISABLE 8'hFF
`define DPAT_WORD_ZERO 32'h0000_0000

// Bus responses
`define DPAT_RESP_OKAY 2'h0
`define DPAT_RESP_SLVERR 2'h2

`endif

// *** hdl/dpat_top.v ***
// Purpose: AXI4-Lite register bank for command aging and line-trap status
// Assumes: Transfer and trap events are pulses from logic on aclk
// Notes: One write and one read in flight; unmapped offsets get SLVERR
//
// Summary of operation
// - Count transfers, then boost oldest command
// - Threshold N means N plus one transfers
// - Threshold FFh never boosts
// - Raw trap flag sets regardless of enable
// - Raw flag one means trap since clear
// - Write one raw clears raw and masked
// - Masked flag sets only when enabled
// - Write one masked clears both flags
// - Write one set enables, both read one
// - Write one clear disables, both read zero
// - Simultaneous set and clear leaves disabled
`include "dpat_map.vh"

module dpat_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [`DPAT_AW-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [`DPAT_DW-1:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [`DPAT_AW-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [`DPAT_DW-1:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Controller events
  input wire xfer_done,
  input wire trap_detect,
  // Controller results
  output wire boost_oldest,
  output wire irq
);

  // Register select codes
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_THRESH = 3'h1;
  localparam [2:0] SEL_RAW = 3'h2;
  localparam [2:0] SEL_MASKED = 3'h3;
  localparam [2:0] SEL_EN_SET = 3'h4;
  localparam [2:0] SEL_EN_CLR = 3'h5;
  localparam [2:0] SEL_AGE_STAT = 3'h6;

  // Address decode shared by the read and write paths
  function [2:0] reg_sel;
    input [`DPAT_AW-1:0] addr;
    begin
      case ({addr[`DPAT_AW-1:2], 2'b00})
        `DPAT_OFF_THRESH: reg_sel = SEL_THRESH;
        `DPAT_OFF_RAW: reg_sel = SEL_RAW;
        `DPAT_OFF_MASKED: reg_sel = SEL_MASKED;
        `DPAT_OFF_EN_SET: reg_sel = SEL_EN_SET;
        `DPAT_OFF_EN_CLR: reg_sel = SEL_EN_CLR;
        `DPAT_OFF_AGE_STAT: reg_sel = SEL_AGE_STAT;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // Bus state
  reg aw_held_ff;
  reg w_held_ff;
  reg [`DPAT_AW-1:0] awaddr_ff;
  reg [`DPAT_DW-1:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [`DPAT_DW-1:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg awready_ff;
  reg wready_ff;
  reg arready_ff;

  // Software state
  reg [7:0] thresh_ff;
  reg [7:0] boosts_ff;

  // Internal nets
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire wr_fire;
  wire wr_lane0;
  wire wr_bit;
  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  wire flag_clear;
  wire enable_set;
  wire enable_clear;
  wire trap_raw_flag;
  wire trap_masked_flag;
  wire trap_enable;
  wire [7:0] xfer_count;
  wire boost;
  wire nxt_aw_held;
  wire nxt_w_held;
  wire nxt_bvalid;
  wire nxt_rvalid;
  reg [`DPAT_DW-1:0] rd_word;

  // Handshakes; address and data are taken independently, in any order
  assign aw_take = s_axi_awvalid & awready_ff;
  assign w_take = s_axi_wvalid & wready_ff;
  assign ar_take = s_axi_arvalid & arready_ff;

  // Next holding and answer states; the ready flops look one edge ahead
  assign nxt_aw_held = aw_take | (aw_held_ff & ~wr_fire);
  assign nxt_w_held = w_take | (w_held_ff & ~wr_fire);
  assign nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready);
  assign nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);

  // The write lands one edge after both halves are held
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_sel = reg_sel(awaddr_ff);
  assign rd_sel = reg_sel(s_axi_araddr);
  // Only lane 0 holds live bits, other lanes are dropped
  assign wr_lane0 = wr_fire & wstrb_ff[0];
  assign wr_bit = wr_lane0 & wdata_ff[`DPAT_TRAP_BIT];

  // Software strobes; a written zero does nothing
  assign flag_clear = wr_bit &
    ((wr_sel == SEL_RAW) | (wr_sel == SEL_MASKED));
  assign enable_set = wr_bit & (wr_sel == SEL_EN_SET);
  assign enable_clear = wr_bit & (wr_sel == SEL_EN_CLR);

  // Write address and data capture
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= {`DPAT_AW{1'b0}};
      wdata_ff <= `DPAT_WORD_ZERO;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
      end
      if (w_take)
      begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR and change nothing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `DPAT_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_sel == SEL_NONE) ? `DPAT_RESP_SLVERR :
        `DPAT_RESP_OKAY;
    end
    else if (bvalid_ff & s_axi_bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // Threshold register; upper bits are not stored
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      thresh_ff <= `DPAT_THR_RESET;
    end
    else if (wr_lane0 & (wr_sel == SEL_THRESH))
    begin
      thresh_ff <= wdata_ff[`DPAT_THR_MSB:0];
    end
  end

  // Count of boosts issued, wraps; lets software see aging at work
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      boosts_ff <= 8'h00;
    end
    else if (boost)
    begin
      boosts_ff <= boosts_ff + 8'h01;
    end
  end

  // Read mux; every bit not listed reads as zero
  always @*
  begin
    rd_word = `DPAT_WORD_ZERO;
    case (rd_sel)
      SEL_THRESH:
        rd_word[`DPAT_THR_MSB:0] = thresh_ff;
      SEL_RAW:
        rd_word[`DPAT_TRAP_BIT] = trap_raw_flag;
      SEL_MASKED:
        rd_word[`DPAT_TRAP_BIT] = trap_masked_flag;
      SEL_EN_SET:
        rd_word[`DPAT_TRAP_BIT] = trap_enable;
      SEL_EN_CLR:
        rd_word[`DPAT_TRAP_BIT] = trap_enable;
      SEL_AGE_STAT:
      begin
        rd_word[`DPAT_CNT_LSB+7:`DPAT_CNT_LSB] = xfer_count;
        rd_word[`DPAT_BOOSTS_LSB+7:`DPAT_BOOSTS_LSB] = boosts_ff;
      end
      default:
        rd_word = `DPAT_WORD_ZERO;
    endcase
  end

  // Read channel; data are sampled at the address edge
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= `DPAT_WORD_ZERO;
      rresp_ff <= `DPAT_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= (rd_sel == SEL_NONE) ? `DPAT_RESP_SLVERR :
        `DPAT_RESP_OKAY;
    end
    else if (rvalid_ff & s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  // Ready flops; built from next states so no port leaves a gate
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
    end
    else
    begin
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff <= ~nxt_w_held & ~nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
    end
  end

  // Transfer aging
  dpat_age_counter u_age (
    .aclk(aclk),
    .aresetn(aresetn),
    .oldest_cmd_boost_threshold(thresh_ff),
    .xfer_done(xfer_done),
    .xfer_count(xfer_count),
    .boost(boost)
  );

  // Line-trap flags and enable
  dpat_trap_flags u_trap (
    .aclk(aclk),
    .aresetn(aresetn),
    .trap_detect(trap_detect),
    .flag_clear(flag_clear),
    .enable_set(enable_set),
    .enable_clear(enable_clear),
    .trap_raw_flag(trap_raw_flag),
    .trap_masked_flag(trap_masked_flag),
    .trap_enable(trap_enable)
  );

  // Ports straight from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign boost_oldest = boost;
  // Interrupt is the masked flag itself, no extra lag
  assign irq = trap_masked_flag;

endmodule // dpat_top

// *** hdl/dpat_trap_flags.v ***
// Purpose: Raw and masked line-trap flags and the trap enable
// Assumes: All strobes are one-cycle pulses on aclk
// Notes: A trap in the clearing cycle wins over the clear at the raw flag, and at the masked flag while enabled
`include "dpat_map.vh"

module dpat_trap_flags (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Events and software strobes
  input wire trap_detect,
  input wire flag_clear,
  input wire enable_set,
  input wire enable_clear,
  // State
  output wire trap_raw_flag,
  output wire trap_masked_flag,
  output wire trap_enable
);

  reg raw_ff;
  reg masked_ff;
  reg enable_ff;
  reg nxt_raw;
  reg nxt_masked;
  reg nxt_enable;

  // Next flag and enable values
  always @*
  begin
    nxt_raw = trap_detect | (raw_ff & ~flag_clear);
    nxt_masked = (trap_detect & enable_ff) |
      (masked_ff & ~flag_clear);
    nxt_enable = enable_ff;
    if (enable_clear)
    begin
      nxt_enable = 1'b0;
    end
    else if (enable_set)
    begin
      nxt_enable = 1'b1;
    end
  end

  // Flag state
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      raw_ff <= 1'b0;
      masked_ff <= 1'b0;
      enable_ff <= 1'b0;
    end
    else
    begin
      raw_ff <= nxt_raw;
      masked_ff <= nxt_masked;
      enable_ff <= nxt_enable;
    end
  end

  assign trap_raw_flag = raw_ff;
  assign trap_masked_flag = masked_ff;
  assign trap_enable = enable_ff;

endmodule // dpat_trap_flags

// *** tb/dpat_master_model.sv ***
// Purpose: Memory side stand-in: transfer and trap pulses
// Assumes: Tasks are entered right after a rising aclk edge
// Notes: Random gaps reach back-to-back transfers
module dpat_master_model (
  // Clock
  input logic aclk,
  // Events
  output logic xfer_done,
  output logic trap_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet at time zero
  initial
  begin
    xfer_done = 1'b0;
    trap_detect = 1'b0;
  end
  // One pulse per transfer, gap of 0 to 2 cycles
  task automatic xfer(input int n);
    int g;
    repeat (n)
    begin
      xfer_done <= 1'b1;
      @(posedge aclk);
      g = $urandom_range(2);
      if (g != 0)
      begin
        xfer_done <= 1'b0;
        repeat (g) @(posedge aclk);
      end
    end
    xfer_done <= 1'b0;
  endtask
  // One illegal access
  task automatic trap();
    trap_detect <= 1'b1;
    @(posedge aclk);
    trap_detect <= 1'b0;
  endtask
endmodule // dpat_master_model

// *** tb/dpat_props.sv ***
// Purpose: Bus and trap/aging checks on the bank's ports
// Assumes: One clock domain, reset synchronous active low
// Notes: Threshold is not visible here; the bench checks counts
module dpat_props (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Register bus
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Controller events and results
  input logic xfer_done,
  input logic trap_detect,
  input logic boost_oldest,
  input logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshakes that start a write or a read
  sequence aw_w_hs;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  b_answer_a: assert property (aw_w_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late or early");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  aw_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  ar_answer_a: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  irq_rise_a: assert property ($rose(irq) |-> $past(trap_detect))
    else $error("irq without trap");
  irq_fall_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq fell without write");
  // Not in the edge a clear lands: with the enable off irq may drop there
  irq_keep_a: assert property (trap_detect && irq &&
    (s_axi_awready || s_axi_wready || s_axi_bvalid) |=> irq)
    else $error("irq lost on trap");
  boost_cause_a: assert property (boost_oldest |-> $past(xfer_done))
    else $error("boost without transfer");
endmodule // dpat_props

bind dpat_top dpat_props i_props (.*);

// *** tb/test_ddr_priority_aging_and_trap_irq.sv ***
// Purpose: Self-checking bench for the aging and trap bank
// Assumes: Offsets and codes of dpat_map.vh
// Notes: Seeded thresholds and transfer gaps
`include "dpat_map.vh"
module test_ddr_priority_aging_and_trap_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, boost_oldest, irq, xfer_done, trap_detect;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int n_errors, n_checks, n_boost, cyc;
  dpat_top i_dut (.*);
  dpat_master_model i_far (.aclk(aclk), .xfer_done(xfer_done),
    .trap_detect(trap_detect));
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Watchdog and boost tally
  always @(posedge aclk)
  begin
    cyc++;
    if (boost_oldest === 1'b1) n_boost++;
    if (cyc == 5000)
    begin
      n_errors++;
      conclude();
    end
  end
  function automatic int exp_boosts(int n, logic [7:0] t);
    return (t == 8'hFF) ? 0 : n / (t + 1);
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Write holds each channel until taken, bready until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk); // Spacer: the next call never reassigns in this step
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk); // Spacer: the next call never reassigns in this step
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic conclude();
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    logic [7:0] t;
    int b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    aresetn = 1'b0;
    void'($urandom(15140));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`DPAT_OFF_THRESH, 32'h0000_00FF);
    for (int i = 1; i < 5; i++)
      rchk(8'(4 * i), `DPAT_WORD_ZERO);
    // Unmapped place answers with an error
    wr(8'h18, $urandom());
    chk({30'h0, rs}, {30'h0, `DPAT_RESP_SLVERR});
    rchk(8'h18, `DPAT_WORD_ZERO);
    chk({30'h0, rs}, {30'h0, `DPAT_RESP_SLVERR});
    // Boost on exactly the (t+1)th transfer; disabling clears the count
    for (int k = 0; k < 5; k++)
    begin
      t = (k < 3) ? 8'(k) : 8'($urandom_range(6, 3));
      wr(`DPAT_OFF_THRESH, {24'h0, `DPAT_THR_DISABLE});
      wr(`DPAT_OFF_THRESH, ($urandom() & 32'hFFFF_FF00) | {24'h0, t});
      rchk(`DPAT_OFF_THRESH, {24'h0, t});
      b0 = n_boost;
      i_far.xfer(int'(t));
      repeat (3) @(posedge aclk);
      chk(n_boost - b0, 0);
      i_far.xfer(2 * int'(t) + 3);
      repeat (3) @(posedge aclk);
      chk(n_boost - b0, exp_boosts(3 * t + 3, t));
    end
    // Largest live setting: 255 transfers, count seen one short of it
    wr(`DPAT_OFF_THRESH, {24'h0, `DPAT_THR_DISABLE});
    wr(`DPAT_OFF_THRESH, 32'h0000_00FE);
    b0 = n_boost;
    i_far.xfer(254);
    repeat (3) @(posedge aclk);
    chk(n_boost - b0, 0);
    rchk(`DPAT_OFF_AGE_STAT, {16'h0, 8'(n_boost), 8'hFE});
    i_far.xfer(1);
    repeat (3) @(posedge aclk);
    chk(n_boost - b0, 1);
    wr(`DPAT_OFF_THRESH, 32'h0000_00FF);
    b0 = n_boost;
    i_far.xfer(300);
    repeat (3) @(posedge aclk);
    chk(n_boost - b0, exp_boosts(300, 8'hFF));
    // Trap while disabled, then the clears
    i_far.trap();
    rchk(`DPAT_OFF_RAW, 32'h0000_0004);
    rchk(`DPAT_OFF_MASKED, 32'h0000_0000);
    wr(`DPAT_OFF_RAW, 32'hFFFF_FFFB);
    rchk(`DPAT_OFF_RAW, 32'h0000_0004);
    wr(`DPAT_OFF_MASKED, 32'h0000_0004);
    rchk(`DPAT_OFF_RAW, 32'h0000_0000);
    wr(`DPAT_OFF_EN_SET, 32'h0000_0004);
    chk({30'h0, rs}, {30'h0, `DPAT_RESP_OKAY});
    rchk(`DPAT_OFF_EN_CLR, 32'h0000_0004);
    i_far.trap();
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(`DPAT_OFF_MASKED, 32'h0000_0004);
    // A trap while pending, then one in the edge the clear lands: set wins
    i_far.trap();
    fork
      wr(`DPAT_OFF_RAW, 32'h0000_0004);
      begin
        @(posedge aclk);
        i_far.trap();
      end
    join
    rchk(`DPAT_OFF_RAW, 32'h0000_0004);
    rchk(`DPAT_OFF_MASKED, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`DPAT_OFF_RAW, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(`DPAT_OFF_MASKED, 32'h0000_0000);
    i_far.trap();
    wr(`DPAT_OFF_MASKED, 32'h0000_0004);
    rchk(`DPAT_OFF_RAW, 32'h0000_0000);
    wr(`DPAT_OFF_EN_CLR, 32'h0000_0000);
    rchk(`DPAT_OFF_EN_SET, 32'h0000_0004);
    wr(`DPAT_OFF_EN_CLR, 32'hFFFF_FFFF);
    rchk(`DPAT_OFF_EN_SET, 32'h0000_0000);
    i_far.trap();
    rchk(`DPAT_OFF_MASKED, 32'h0000_0000);
    conclude();
  end
endmodule // test_ddr_priority_aging_and_trap_irq
